// ### hw/flp_consts.svh
// named constants shared by the flash link device end and host end
`ifndef FLP_CONSTS_SVH
`define FLP_CONSTS_SVH

// opcodes fixed by the command set
`define FLP_OP_LOCK_ALL 8'h7E
`define FLP_OP_UNLOCK_ALL 8'h98
`define FLP_OP_READ_PARAM 8'h5A

// frame layout
`define FLP_BIT_FIRST 3'h0
`define FLP_BIT_LAST 3'h7
`define FLP_ONE_BYTE 2'h1
`define FLP_BYTE_SAT 2'h2
`define FLP_ADDR_LAST 2'h2
`define FLP_HDR_BITS_SHORT 12'h008
`define FLP_HDR_BITS_LONG 12'h028
`define FLP_DUMMY_BYTE 8'h00

// sampled pin vector {si, sclk, cs_n} and its idle level
`define FLP_PIN_CS 0
`define FLP_PIN_SCK 1
`define FLP_PIN_SI 2
`define FLP_PIN_IDLE 3'h1

// parameter table contents
`define FLP_TBL_LEN 24'h000018
`define FLP_SIG0 8'h53
`define FLP_SIG1 8'h46
`define FLP_SIG2 8'h44
`define FLP_SIG3 8'h50
`define FLP_REV_MINOR 8'h00
`define FLP_REV_MAJOR 8'h01
`define FLP_NUM_HDR 8'h01
`define FLP_UNUSED 8'hFF
`define FLP_STD_ID 8'h00
`define FLP_LEN0 8'h09
`define FLP_PTR0 8'h30
`define FLP_LEN1 8'h04
`define FLP_PTR1 8'h60
`define FLP_ZERO 8'h00

// host register map, byte addresses
`define FLP_APB_AW 8
`define FLP_REG_CMD 8'h00
`define FLP_REG_ADDR 8'h04
`define FLP_REG_RXDATA 8'h08
`define FLP_REG_STATUS 8'h0C
`define FLP_REG_IRQ_STAT 8'h10
`define FLP_REG_IRQ_CLR 8'h14
`define FLP_REG_IRQ_EN 8'h18

// host register fields
`define FLP_CMD_OP_MSB 7
`define FLP_CMD_OP_LSB 0
`define FLP_CMD_LONG_BIT 8
`define FLP_CMD_NB_MSB 23
`define FLP_CMD_NB_LSB 16
`define FLP_ADDR_MSB 23
`define FLP_IRQ_W 2
`define FLP_IRQ_DONE 0
`define FLP_IRQ_REFUSED 1

// host timing: least half period of the link clock in clk cycles
`define FLP_HALF_MIN 6

`endif

// ### hw/flp_pkg.sv
// types shared by the flash link device end and host end
package flp_pkg;

	typedef enum logic [2:0] {
		DS_CMD = 3'b000,
		DS_ADDR = 3'b001,
		DS_DUMMY = 3'b010,
		DS_DATA = 3'b011,
		DS_IGNORE = 3'b100
	} flp_dev_st_e;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SHIFT = 2'b01,
		HS_TAIL = 2'b10,
		HS_GAP = 2'b11
	} flp_host_st_e;

	typedef logic [7:0] flp_byte_t;

endpackage : flp_pkg

// ### hw/flp_link_if.sv
// serial link between the flash device end and its host end
`timescale 1ns/1ps
interface flp_link_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe;

	modport dev (
		input cs_n,
		input sclk,
		input si,
		output so,
		output so_oe
	);

	modport host (
		output cs_n,
		output sclk,
		output si,
		input so
	);
endinterface : flp_link_if

// ### hw/flp_dev.sv
// flash device end: gang lock, fail flags, busy output, parameter table
`timescale 1ns/1ps
`include "flp_consts.svh"
module flp_dev #(
	parameter int NUM_BLOCKS = 128,
	parameter flp_pkg::flp_byte_t OP_WRITE_EN = 8'hA0,
	parameter flp_pkg::flp_byte_t OP_CLEAR_FAIL = 8'hA1,
	parameter flp_pkg::flp_byte_t OP_BUSY_ON = 8'hA2,
	parameter flp_pkg::flp_byte_t OP_BUSY_OFF = 8'hA3,
	// arbitrary value
	parameter flp_pkg::flp_byte_t VENDOR_ID = 8'hA5
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// serial link
	flp_link_if.dev link,
	// array state from the rest of the device
	input wire logic block_protect_select,
	input wire logic continuous_program_mode,
	input wire logic busy,
	input wire logic prog_fail_set,
	input wire logic erase_fail_set,
	// state shown to the rest of the device
	output logic [NUM_BLOCKS-1:0] block_lock,
	output logic prog_failed,
	output logic erase_failed,
	output logic write_enable_latch,
	output logic busy_output_en
);
	import flp_pkg::*;

	if (NUM_BLOCKS < 1) begin : g_bad_blocks
		$error("NUM_BLOCKS must be at least 1");
	end

	localparam int IDXW = $clog2(`FLP_TBL_LEN);
	localparam flp_byte_t TBL [0:`FLP_TBL_LEN-1] = '{
		`FLP_SIG0, `FLP_SIG1, `FLP_SIG2, `FLP_SIG3,
		`FLP_REV_MINOR, `FLP_REV_MAJOR, `FLP_NUM_HDR, `FLP_UNUSED,
		`FLP_STD_ID, `FLP_REV_MINOR, `FLP_REV_MAJOR, `FLP_LEN0,
		`FLP_PTR0, `FLP_ZERO, `FLP_ZERO, `FLP_UNUSED,
		VENDOR_ID, `FLP_REV_MINOR, `FLP_REV_MAJOR, `FLP_LEN1,
		`FLP_PTR1, `FLP_ZERO, `FLP_ZERO, `FLP_UNUSED
	};

	// **********************************************************
	// pin sampling
	// **********************************************************
	logic [2:0] pin_a_q;
	logic [2:0] pin_b_q;
	logic [2:0] pin_c_q;
	logic [2:0] pin_st_q;
	logic [2:0] pin_prev_q;
	logic [2:0] agree;
	logic cs_n_st;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;

	// a level counts only once the second and third stages agree
	assign agree = ~(pin_b_q ^ pin_c_q);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_a_q <= `FLP_PIN_IDLE;
			pin_b_q <= `FLP_PIN_IDLE;
			pin_c_q <= `FLP_PIN_IDLE;
			pin_st_q <= `FLP_PIN_IDLE;
			pin_prev_q <= `FLP_PIN_IDLE;
		end else if (ce) begin
			pin_a_q <= {link.si, link.sclk, link.cs_n};
			pin_b_q <= pin_a_q;
			pin_c_q <= pin_b_q;
			pin_st_q <= (pin_st_q & ~agree) | (pin_c_q & agree);
			pin_prev_q <= pin_st_q;
		end
	end

	assign cs_n_st = pin_st_q[`FLP_PIN_CS];
	assign sck_rise = ~cs_n_st & pin_st_q[`FLP_PIN_SCK]
		& ~pin_prev_q[`FLP_PIN_SCK];
	assign sck_fall = ~cs_n_st & ~pin_st_q[`FLP_PIN_SCK]
		& pin_prev_q[`FLP_PIN_SCK];
	assign cs_rise = cs_n_st & ~pin_prev_q[`FLP_PIN_CS];

	// **********************************************************
	// byte framing
	// **********************************************************
	logic [7:0] rx_sh_q;
	logic [2:0] bit_cnt_q;
	logic [1:0] byte_cnt_q;
	logic [7:0] rx_byte;
	logic byte_done;

	assign rx_byte = {rx_sh_q[6:0], pin_st_q[`FLP_PIN_SI]};
	assign byte_done = sck_rise && bit_cnt_q == `FLP_BIT_LAST;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_sh_q <= '0;
			bit_cnt_q <= '0;
			byte_cnt_q <= '0;
		end else if (ce) begin
			if (cs_n_st) begin
				bit_cnt_q <= '0;
				byte_cnt_q <= '0;
			end else if (sck_rise) begin
				rx_sh_q <= rx_byte;
				bit_cnt_q <= bit_cnt_q + 3'h1;
				if (byte_done && byte_cnt_q != `FLP_BYTE_SAT) begin
					byte_cnt_q <= byte_cnt_q + 2'h1;
				end
			end
		end
	end

	// **********************************************************
	// frame sequence
	// **********************************************************
	flp_dev_st_e state_q;
	flp_byte_t opcode_q;
	logic [23:0] addr_q;
	logic [1:0] addr_cnt_q;
	logic [2:0] out_cnt_q;
	logic load_out;
	flp_byte_t tbl_byte;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= DS_CMD;
			opcode_q <= '0;
		end else if (ce) begin
			if (cs_n_st) begin
				state_q <= DS_CMD;
			end else if (byte_done) begin
				unique case (state_q)
					DS_CMD: begin
						opcode_q <= rx_byte;
						if (rx_byte == `FLP_OP_READ_PARAM) begin
							state_q <= DS_ADDR;
						end else begin
							state_q <= DS_IGNORE;
						end
					end
					DS_ADDR: begin
						if (addr_cnt_q == `FLP_ADDR_LAST) begin
							state_q <= DS_DUMMY;
						end
					end
					DS_DUMMY: state_q <= DS_DATA;
					DS_DATA: state_q <= DS_DATA;
					DS_IGNORE: state_q <= DS_IGNORE;
					default: state_q <= DS_CMD;
				endcase
			end
		end
	end

	assign load_out = sck_fall && state_q == DS_DATA
		&& out_cnt_q == `FLP_BIT_FIRST;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= '0;
			addr_cnt_q <= '0;
		end else if (ce) begin
			if (cs_n_st) begin
				addr_cnt_q <= '0;
			end else if (byte_done && state_q == DS_ADDR) begin
				addr_q <= {addr_q[15:0], rx_byte};
				addr_cnt_q <= addr_cnt_q + 2'h1;
			end else if (load_out) begin
				addr_q <= addr_q + 24'h000001;
			end
		end
	end

	// beyond the two headers the table is not held here
	assign tbl_byte = (addr_q < `FLP_TBL_LEN) ? TBL[addr_q[IDXW-1:0]]
		: `FLP_UNUSED;

	// **********************************************************
	// serial output
	// **********************************************************
	logic [7:0] out_sh_q;
	logic dbit_q;
	logic so_q;
	logic so_oe_q;
	logic reading;
	logic busy_drive;
	logic busy_out_en_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_cnt_q <= '0;
			out_sh_q <= '0;
			dbit_q <= 1'b0;
		end else if (ce) begin
			if (cs_n_st) begin
				out_cnt_q <= '0;
			end else if (sck_fall && state_q == DS_DATA) begin
				out_cnt_q <= out_cnt_q + 3'h1;
				if (load_out) begin
					dbit_q <= tbl_byte[7];
					out_sh_q <= {tbl_byte[6:0], 1'b0};
				end else begin
					dbit_q <= out_sh_q[7];
					out_sh_q <= {out_sh_q[6:0], 1'b0};
				end
			end
		end
	end

	// ready/busy only between frames so it never fights table data
	assign reading = ~cs_n_st && state_q == DS_DATA;
	assign busy_drive = continuous_program_mode && busy_out_en_q
		&& cs_n_st;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			so_q <= 1'b1;
			so_oe_q <= 1'b0;
		end else if (ce) begin
			so_q <= reading ? dbit_q : ~busy;
			so_oe_q <= reading | busy_drive;
		end
	end

	assign link.so = so_q;
	assign link.so_oe = so_oe_q;

	// **********************************************************
	// single-byte commands
	// **********************************************************
	logic single;
	logic wel_q;
	logic lock_go;
	logic unlock_go;
	logic clear_go;
	logic [NUM_BLOCKS-1:0] lock_q;
	logic prog_failed_q;
	logic erase_failed_q;

	// executes only on a frame of exactly one whole byte
	assign single = cs_rise && byte_cnt_q == `FLP_ONE_BYTE
		&& bit_cnt_q == `FLP_BIT_FIRST && state_q == DS_IGNORE;
	assign lock_go = single && opcode_q == `FLP_OP_LOCK_ALL
		&& block_protect_select && wel_q;
	assign unlock_go = single && opcode_q == `FLP_OP_UNLOCK_ALL
		&& block_protect_select && wel_q;
	assign clear_go = single && opcode_q == OP_CLEAR_FAIL;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wel_q <= 1'b0;
		end else if (ce) begin
			if (single && opcode_q == OP_WRITE_EN) begin
				wel_q <= 1'b1;
			end else if (lock_go || unlock_go) begin
				wel_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lock_q <= '1;
		end else if (ce) begin
			if (lock_go) begin
				lock_q <= '1;
			end else if (unlock_go) begin
				lock_q <= '0;
			end
		end
	end

	// a failure reported in the clearing cycle survives the clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prog_failed_q <= 1'b0;
			erase_failed_q <= 1'b0;
		end else if (ce) begin
			prog_failed_q <= prog_fail_set
				| (prog_failed_q & ~clear_go);
			erase_failed_q <= erase_fail_set
				| (erase_failed_q & ~clear_go);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_out_en_q <= 1'b0;
		end else if (ce) begin
			if (single && opcode_q == OP_BUSY_ON) begin
				busy_out_en_q <= 1'b1;
			end else if (single && opcode_q == OP_BUSY_OFF) begin
				busy_out_en_q <= 1'b0;
			end
		end
	end

	assign block_lock = lock_q;
	assign prog_failed = prog_failed_q;
	assign erase_failed = erase_failed_q;
	assign write_enable_latch = wel_q;
	assign busy_output_en = busy_out_en_q;
endmodule : flp_dev

// ### hw/flp_host.sv
// flash link host end: APB command registers driving the serial link
`timescale 1ns/1ps
`include "flp_consts.svh"
module flp_host #(
	parameter int HALF = 8
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`FLP_APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// serial link
	flp_link_if.host link
);
	import flp_pkg::*;

	// the device end needs several cycles to see each link edge
	if (HALF < `FLP_HALF_MIN) begin : g_bad_half
		$error("HALF too short for the device end to follow");
	end

	localparam int DW = $clog2(HALF + 1);

	// **********************************************************
	// register bus
	// **********************************************************
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic hit;
	logic wr_go;
	logic start;
	logic busy;
	logic so_st_q;
	flp_byte_t op_q;
	logic long_q;
	logic [7:0] nb_q;
	logic [23:0] addr_q;
	logic [31:0] rx_q;
	logic [`FLP_IRQ_W-1:0] irq_stat_q;
	logic [`FLP_IRQ_W-1:0] irq_en_q;
	logic [`FLP_IRQ_W-1:0] irq_set;
	logic [`FLP_IRQ_W-1:0] irq_clr;
	logic irq_q;

	always_comb begin
		hit = 1'b1;
		rd_mux = '0;
		unique case (paddr)
			`FLP_REG_CMD: rd_mux = {8'h00, nb_q, 7'h00, long_q, op_q};
			`FLP_REG_ADDR: rd_mux = {8'h00, addr_q};
			`FLP_REG_RXDATA: rd_mux = rx_q;
			`FLP_REG_STATUS: rd_mux = {30'h0, so_st_q, busy};
			`FLP_REG_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
			`FLP_REG_IRQ_CLR: rd_mux = '0;
			`FLP_REG_IRQ_EN: rd_mux = {30'h0, irq_en_q};
			default: hit = 1'b0;
		endcase
	end

	// one wait state so read data can leave a flip-flop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else if (ce) begin
			pready_q <= psel && penable && !pready_q;
			if (psel && penable && !pready_q) begin
				pslverr_q <= ~hit;
				prdata_q <= (pwrite || !hit) ? 32'h0 : rd_mux;
			end
		end
	end

	assign pready = pready_q;
	assign pslverr = pready_q & pslverr_q;
	assign prdata = prdata_q;
	assign wr_go = psel && penable && pwrite && pready_q && hit;
	assign start = wr_go && paddr == `FLP_REG_CMD && !busy;
	assign irq_clr = (wr_go && paddr == `FLP_REG_IRQ_CLR)
		? pwdata[`FLP_IRQ_W-1:0] : '0;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			op_q <= '0;
			long_q <= 1'b0;
			nb_q <= '0;
			addr_q <= '0;
			irq_en_q <= '0;
		end else if (ce) begin
			if (start) begin
				op_q <= pwdata[`FLP_CMD_OP_MSB:`FLP_CMD_OP_LSB];
				long_q <= pwdata[`FLP_CMD_LONG_BIT];
				nb_q <= pwdata[`FLP_CMD_NB_MSB:`FLP_CMD_NB_LSB];
			end
			if (wr_go && paddr == `FLP_REG_ADDR) begin
				addr_q <= pwdata[`FLP_ADDR_MSB:0];
			end
			if (wr_go && paddr == `FLP_REG_IRQ_EN) begin
				irq_en_q <= pwdata[`FLP_IRQ_W-1:0];
			end
		end
	end

	// **********************************************************
	// serial engine
	// **********************************************************
	flp_host_st_e state_q;
	logic [DW-1:0] div_q;
	logic tick;
	logic cs_n_q;
	logic sclk_q;
	logic si_q;
	logic [39:0] tx_q;
	logic [11:0] rises_q;
	logic [11:0] total_q;
	logic [11:0] hdr_q;
	logic [11:0] hdr;
	flp_byte_t op_in;
	logic [2:0] so_sync_q;
	logic done;

	assign busy = state_q != HS_IDLE;
	assign tick = div_q == DW'(HALF - 1);
	assign op_in = pwdata[`FLP_CMD_OP_MSB:`FLP_CMD_OP_LSB];
	assign hdr = pwdata[`FLP_CMD_LONG_BIT] ? `FLP_HDR_BITS_LONG
		: `FLP_HDR_BITS_SHORT;
	assign done = state_q == HS_GAP && tick;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			so_sync_q <= '0;
			so_st_q <= 1'b0;
		end else if (ce) begin
			so_sync_q <= {so_sync_q[1:0], link.so};
			if (so_sync_q[1] == so_sync_q[2]) begin
				so_st_q <= so_sync_q[2];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= HS_IDLE;
			div_q <= '0;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			si_q <= 1'b0;
			tx_q <= '0;
			rises_q <= '0;
			total_q <= '0;
			hdr_q <= '0;
			rx_q <= '0;
		end else if (ce) begin
			div_q <= (tick || !busy) ? '0 : div_q + DW'(1);
			unique case (state_q)
				HS_IDLE: begin
					if (start) begin
						state_q <= HS_SHIFT;
						cs_n_q <= 1'b0;
						si_q <= op_in[7];
						tx_q <= {op_in[6:0], pwdata[`FLP_CMD_LONG_BIT]
							? {addr_q, `FLP_DUMMY_BYTE} : 32'h0, 1'b0};
						rises_q <= '0;
						hdr_q <= hdr;
						// whole bytes only, so chip select rises on a boundary
						total_q <= hdr + {1'b0,
							pwdata[`FLP_CMD_NB_MSB:`FLP_CMD_NB_LSB], 3'h0};
					end
				end
				HS_SHIFT: begin
					if (tick) begin
						sclk_q <= ~sclk_q;
						if (!sclk_q) begin
							rises_q <= rises_q + 12'h001;
						end else begin
							if (rises_q > hdr_q) begin
								rx_q <= {rx_q[30:0], so_st_q};
							end
							if (rises_q == total_q) begin
								state_q <= HS_TAIL;
							end else begin
								si_q <= tx_q[39];
								tx_q <= {tx_q[38:0], 1'b0};
							end
						end
					end
				end
				HS_TAIL: begin
					if (tick) begin
						cs_n_q <= 1'b1;
						state_q <= HS_GAP;
					end
				end
				HS_GAP: begin
					if (tick) begin
						state_q <= HS_IDLE;
					end
				end
			endcase
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign link.si = si_q;

	// **********************************************************
	// interrupts
	// **********************************************************
	assign irq_set[`FLP_IRQ_DONE] = done;
	assign irq_set[`FLP_IRQ_REFUSED] = wr_go && paddr == `FLP_REG_CMD
		&& busy;

	// a new event in the clearing cycle stays set
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_q <= '0;
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			irq_q <= |(irq_stat_q & irq_en_q);
		end
	end

	assign irq = irq_q;
endmodule : flp_host

// ### tb/flp_link_sva.sv
// concurrent checks on the serial link between host end and device end
`timescale 1ns/1ps
module flp_link_sva (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// serial link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic [2:0] bits_q;
	logic sclk_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// ****************************************
	// helper: link clock rises within a frame
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bits_q <= 3'h0;
		end else if (cs_n) begin
			bits_q <= 3'h0;
		end else if (sclk && !sclk_q) begin
			bits_q <= bits_q + 3'h1;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("link clock runs outside a frame");
	sclk_high_a: assert property ($rose(sclk) |-> sclk [*6])
		else $error("link clock high phase too short");
	si_hold_a: assert property (!cs_n && sclk |-> $stable(si))
		else $error("serial input moved while link clock high");
	cs_lead_a: assert property ($fell(cs_n) |-> !sclk [*6])
		else $error("link clock too soon after select");
	cs_tail_a: assert property ($rose(cs_n) |-> $past(sclk, 6) == 1'b0)
		else $error("select released too soon after last fall");
	byte_edge_a: assert property ($rose(cs_n) |-> bits_q == 3'h0)
		else $error("frame ended off a byte boundary");
	rb_quiet_a: assert property ($fell(cs_n) |-> ##[1:8] !so_oe)
		else $error("ready busy still driven inside a frame");
	so_hold_a: assert property (
		!cs_n && so_oe && $past(so_oe) && sclk && $past(sclk)
		|-> $stable(so))
		else $error("read data moved while link clock high");
	read_end_a: assert property ($rose(cs_n) |-> ##[1:10] !so_oe)
		else $error("read data still driven after select release");

	cover property ($rose(so_oe) && !cs_n);
	cover property ($rose(cs_n) && so_oe);
	cover property (cs_n && so_oe);
endmodule : flp_link_sva

// ### tb/test_flash_lock_status_sfdp_commands.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/1ps
`include "flp_consts.svh"
module test_flash_lock_status_sfdp_commands;
	import flp_pkg::*;
	localparam flp_byte_t OP_WE = 8'hA0;
	localparam flp_byte_t OP_CLR = 8'hA1;
	localparam flp_byte_t OP_ON = 8'hA2;
	localparam flp_byte_t OP_OFF = 8'hA3;
	// arbitrary value
	localparam flp_byte_t VEND = 8'h5C;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic bps, cpm, busy, pfs, efs, pf, ef, wel, boe, e;
	logic [127:0] block_lock;
	int error_cnt, compares;

	flp_link_if flp_link_if_i ();
	flp_dev #(.OP_WRITE_EN(OP_WE), .OP_CLEAR_FAIL(OP_CLR),
		.OP_BUSY_ON(OP_ON), .OP_BUSY_OFF(OP_OFF), .VENDOR_ID(VEND)) flp_dev_i (
		.clk(clk), .nrst(nrst), .ce(1'b1), .link(flp_link_if_i),
		.block_protect_select(bps), .continuous_program_mode(cpm),
		.busy(busy), .prog_fail_set(pfs), .erase_fail_set(efs),
		.block_lock(block_lock), .prog_failed(pf), .erase_failed(ef),
		.write_enable_latch(wel), .busy_output_en(boe));
	flp_host flp_host_i (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.link(flp_link_if_i));
	flp_link_sva flp_link_sva_i (.clk(clk), .nrst(nrst),
		.cs_n(flp_link_if_i.cs_n), .sclk(flp_link_if_i.sclk),
		.si(flp_link_if_i.si), .so(flp_link_if_i.so),
		.so_oe(flp_link_if_i.so_oe));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// read data and response are taken at the accepting rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a slave that never answers counts as a mismatch
		if (pready !== 1'b1) begin
			error_cnt++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wdone();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk(irq, 1'b1);
		apb(1'b1, `FLP_REG_IRQ_CLR, 32'h00000003);
	endtask : wdone

	task automatic cmd(input logic [31:0] w);
		apb(1'b1, `FLP_REG_CMD, w);
		wdone();
	endtask : cmd

	function automatic flp_byte_t tb_byte(input int a);
		case (a)
			0: return 8'h53;
			1: return 8'h46;
			2: return 8'h44;
			3: return 8'h50;
			5, 6, 10, 18: return 8'h01;
			4, 8, 9, 13, 14, 17, 21, 22: return 8'h00;
			11: return 8'h09;
			12: return 8'h30;
			16: return VEND;
			19: return 8'h04;
			20: return 8'h60;
			default: return 8'hFF;
		endcase
	endfunction : tb_byte

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		chk(&block_lock, 1'b1);
		chk({pf, ef, wel}, 3'h0);
		apb(1'b0, 8'h40, 32'h00000000);
		chk(e, 1'b1);
		chk(r, 32'h00000000);
		apb(1'b1, `FLP_REG_CMD, {24'h000000, OP_WE});
		apb(1'b1, `FLP_REG_CMD, {24'h000000, OP_WE});
		apb(1'b0, `FLP_REG_IRQ_STAT, 32'h00000000);
		chk(r, 32'h00000002);
		chk(irq, 1'b0);
		wdone();
		apb(1'b0, `FLP_REG_IRQ_STAT, 32'h00000000);
		chk(irq, 1'b0);
		chk(r, 32'h00000000);
		$display("test regs done");
	endtask : t_regs

	task automatic t_lock();
		cmd({24'h000000, OP_WE});
		chk(wel, 1'b1);
		cmd({24'h000000, `FLP_OP_UNLOCK_ALL});
		chk({&block_lock, wel}, 2'h3);
		@(posedge clk);
		bps <= 1'b1;
		cmd({24'h000000, `FLP_OP_UNLOCK_ALL});
		chk({|block_lock, wel}, 2'h0);
		cmd({24'h000000, `FLP_OP_LOCK_ALL});
		chk(|block_lock, 1'b0);
		cmd({24'h000000, OP_WE});
		cmd({24'h000000, `FLP_OP_LOCK_ALL});
		chk({&block_lock, wel}, 2'h2);
		// a two-byte frame is not on the single-byte boundary
		cmd(32'h000100A0);
		chk(wel, 1'b0);
		$display("test lock done");
	endtask : t_lock

	task automatic t_flags();
		@(posedge clk);
		pfs <= 1'b1;
		efs <= 1'b1;
		@(posedge clk);
		pfs <= 1'b0;
		efs <= 1'b0;
		repeat (2) @(negedge clk);
		chk({pf, ef}, 2'h3);
		cmd({24'h000000, OP_CLR});
		chk({pf, ef}, 2'h0);
		$display("test flags done");
	endtask : t_flags

	task automatic t_busy();
		@(posedge clk);
		cpm <= 1'b1;
		busy <= 1'b1;
		cmd({24'h000000, OP_ON});
		chk({boe, flp_link_if_i.so_oe, flp_link_if_i.so}, 3'h6);
		apb(1'b0, `FLP_REG_STATUS, 32'h00000000);
		chk(r, 32'h00000000);
		@(posedge clk);
		busy <= 1'b0;
		repeat (12) @(negedge clk);
		chk(flp_link_if_i.so, 1'b1);
		apb(1'b0, `FLP_REG_STATUS, 32'h00000000);
		chk(r, 32'h00000002);
		cmd({24'h000000, OP_OFF});
		chk({boe, flp_link_if_i.so_oe}, 2'h0);
		@(posedge clk);
		cpm <= 1'b0;
		$display("test busy done");
	endtask : t_busy

	// four-byte reads step through the whole table and past its end
	task automatic t_table();
		int a;
		for (a = 0; a <= 28; a += 2) begin
			apb(1'b1, `FLP_REG_ADDR, a);
			cmd(32'h0004015A);
			apb(1'b0, `FLP_REG_RXDATA, 32'h00000000);
			chk(r, {tb_byte(a), tb_byte(a + 1), tb_byte(a + 2),
				tb_byte(a + 3)});
			chk(flp_link_if_i.so_oe, 1'b0);
		end
		$display("test table done");
	endtask : t_table

	task automatic stop_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	// ****************************************
	// clock, reset, sequence, watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		stop_test();
	end

	initial begin
		{nrst, psel, penable, pwrite, bps, cpm, busy, pfs, efs} = 9'h000;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		error_cnt = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		apb(1'b1, `FLP_REG_IRQ_EN, 32'h00000001);
		t_regs();
		t_lock();
		t_flags();
		t_busy();
		t_table();
		stop_test();
	end
endmodule : test_flash_lock_status_sfdp_commands
